// ==== wbaf_top.sv ====
// Operation
// - wired frames are stored whole before radio; radio frames stored whole before download
// - eight independent upload buffers hold wired frames awaiting radio
// - collide mode: no free upload buffer raises collision toward the station
// - discard mode: no free upload buffer drops the frame silently
// - source address of every stored wired frame of 12 to 1536 bytes is learned while the table has a free slot; one frame suffices
// - local receiver decided by looking destination up in the learned table
// - ack enabled: acknowledge good radio frame only if destination is local
// - transmit filter: wired frame to a local destination is not sent over radio
// - download filter: radio frame to a non-local destination is not downloaded
// - crc is checked before any address is examined on received frames
// - entry removed after aging time without traffic; new frames restart aging
// - radio frame carrying a locally learned source deletes that entry at once
// - learned table is volatile and empty after every reset
// - a learned address becomes effective well within 20 ms of its frame
// - reset defaults: ack, both filters, loop detect on; duplicate tracking off
`include "wbaf_defs.svh"

module wbaf_top #(
  parameter int TICK_CYCLES = `WBAF_TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cfg_write_i,
  input wire logic cfg_ack_en_i,
  input wire logic cfg_tx_filter_i,
  input wire logic cfg_dl_filter_i,
  input wire logic cfg_loop_detect_i,
  input wire logic cfg_dup_track_i,
  input wire logic cfg_collide_i,
  input wire logic [15:0] cfg_aging_s_i,
  output wire logic cfg_ack_en_o,
  output wire logic cfg_tx_filter_o,
  output wire logic cfg_dl_filter_o,
  output wire logic cfg_loop_detect_o,
  output wire logic cfg_dup_track_o,
  output wire logic cfg_collide_o,
  output wire logic [15:0] cfg_aging_s_o,
  input wire logic up_valid_i,
  input wire logic [7:0] up_data_i,
  input wire logic up_last_i,
  output wire logic collision_o,
  output wire logic rf_tx_valid_o,
  output wire logic [7:0] rf_tx_data_o,
  output wire logic rf_tx_last_o,
  input wire logic rf_tx_ready_i,
  input wire logic rf_rx_valid_i,
  input wire logic [7:0] rf_rx_data_i,
  input wire logic rf_rx_last_i,
  input wire logic rf_rx_crc_ok_i,
  output wire logic ack_o,
  output wire logic rx_drop_o,
  output wire logic dl_valid_o,
  output wire logic [7:0] dl_data_o,
  output wire logic dl_last_o,
  input wire logic dl_ready_i,
  output wire logic [7:0] up_buf_busy_o,
  output wire logic [15:0] tbl_valid_o
);
  import wbaf_pkg::*;

  localparam int NE = `WBAF_TBL_ENTRIES;

  // lowest set bit wins; returns {any, index}
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // configuration
  logic ack_en;
  logic tx_filter;
  logic dl_filter;
  logic loop_detect;
  logic dup_track;
  logic collide_mode;
  logic [15:0] aging_s;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ack_en <= `WBAF_RST_ACK_EN;
      tx_filter <= `WBAF_RST_TX_FILTER;
      dl_filter <= `WBAF_RST_DL_FILTER;
      loop_detect <= `WBAF_RST_LOOP_DETECT;
      dup_track <= `WBAF_RST_DUP_TRACK;
      collide_mode <= `WBAF_RST_COLLIDE;
      aging_s <= `WBAF_AGING_S;
    end else if (cfg_write_i) begin
      ack_en <= cfg_ack_en_i;
      tx_filter <= cfg_tx_filter_i;
      dl_filter <= cfg_dl_filter_i;
      loop_detect <= cfg_loop_detect_i;
      dup_track <= cfg_dup_track_i;
      collide_mode <= cfg_collide_i;
      aging_s <= cfg_aging_s_i;
    end
  end

  assign cfg_ack_en_o = ack_en;
  assign cfg_tx_filter_o = tx_filter;
  assign cfg_dl_filter_o = dl_filter;
  assign cfg_loop_detect_o = loop_detect;
  assign cfg_dup_track_o = dup_track;
  assign cfg_collide_o = collide_mode;
  assign cfg_aging_s_o = aging_s;

  // one-second aging tick
  logic [31:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clock_i) begin
    if (reset_i || tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // upload side state
  wbaf_wr_state_type wr_state;
  logic [2:0] wr_buf;
  logic [10:0] wr_cnt;
  logic wr_long;
  logic [95:0] up_hdr;
  logic [7:0] buf_full;
  logic [10:0] buf_len [`WBAF_UP_BUFS];
  logic [2:0] tx_q [`WBAF_UP_BUFS];
  logic [3:0] q_wr;
  logic [3:0] q_rd;
  logic [7:0] up_mem [`WBAF_UP_BUFS * `WBAF_BUF_DEPTH];

  // receive side state
  wbaf_rx_state_type rx_state;
  logic [10:0] rx_cnt;
  logic rx_long;
  logic [95:0] rx_hdr;
  logic rx_crc_ok;
  logic ack;
  logic rx_drop;
  logic [7:0] rx_mem [`WBAF_BUF_DEPTH];

  // table
  logic ent_valid [NE];
  wbaf_mac_type ent_mac [NE];
  logic [15:0] ent_age [NE];
  wire [NE-1:0] hit_up_dst;
  wire [NE-1:0] hit_learn;
  wire [NE-1:0] hit_rx_dst;
  wire [NE-1:0] hit_rx_src;
  wire [NE-1:0] ent_free;

  // upload decode
  wire [7:0] wr_mask = (wr_state == WR_STORE || wr_state == WR_COMMIT) ? (8'h01 << wr_buf) : 8'h00;
  wire [7:0] buf_avail = ~buf_full & ~wr_mask;
  wire [4:0] free_buf = first_set({8'h00, buf_avail});
  wire buf_any = free_buf[4];
  wire [2:0] buf_idx = free_buf[2:0];
  wire up_start = up_valid_i && (wr_state == WR_IDLE);
  wire up_len_ok = !wr_long && (wr_cnt >= `WBAF_HDR_BYTES);
  wire up_commit = (wr_state == WR_COMMIT);
  wire up_dst_local = |hit_up_dst;
  wire forward = up_commit && up_len_ok && !(tx_filter && up_dst_local);
  wire learn_req = up_commit && up_len_ok;
  wire up_we = up_valid_i && (up_start ? buf_any : (wr_state == WR_STORE))
               && (wr_cnt < `WBAF_FRAME_MAX || up_start);
  wire [13:0] up_waddr = up_start ? {buf_idx, 11'h000} : {wr_buf, wr_cnt};

  // collision only while offering a frame that found every buffer taken, held until its last byte
  assign collision_o = collide_mode && ((up_start && !buf_any) || wr_state == WR_COLLIDE);

  // wired frame intake; needs one idle cycle between frames for commit
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_state <= WR_IDLE;
      wr_buf <= 3'h0;
      wr_cnt <= 11'h000;
      wr_long <= 1'b0;
      up_hdr <= 96'h0;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (up_valid_i && buf_any) begin
            wr_buf <= buf_idx;
            wr_cnt <= 11'h001;
            wr_long <= 1'b0;
            up_hdr <= {88'h0, up_data_i};
            wr_state <= up_last_i ? WR_COMMIT : WR_STORE;
          end else if (up_valid_i && !up_last_i) begin
            wr_state <= collide_mode ? WR_COLLIDE : WR_DISCARD;
          end
        end
        WR_STORE: begin
          if (up_valid_i) begin
            if (wr_cnt < `WBAF_FRAME_MAX) begin
              wr_cnt <= wr_cnt + 11'h001;
            end else begin
              wr_long <= 1'b1;
            end
            if (wr_cnt < `WBAF_HDR_BYTES) begin
              up_hdr <= {up_hdr[87:0], up_data_i};
            end
            if (up_last_i) begin
              wr_state <= WR_COMMIT;
            end
          end
        end
        WR_COMMIT: begin
          wr_state <= WR_IDLE;
        end
        WR_COLLIDE, WR_DISCARD: begin
          if (up_valid_i && up_last_i) begin
            wr_state <= WR_IDLE;
          end
        end
        default: begin
          wr_state <= WR_IDLE;
        end
      endcase
    end
  end

  // upload buffer storage
  always_ff @(posedge clock_i) begin
    if (up_we) begin
      up_mem[up_waddr] <= up_data_i;
    end
  end

  // radio transmit reader
  logic tx_active;
  logic [2:0] tx_buf;
  logic [10:0] tx_rd;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_last;

  wire tx_adv = !tx_valid || rf_tx_ready_i;
  wire q_empty = (q_wr == q_rd);
  wire tx_rd_last = (tx_rd == (buf_len[tx_buf] - 11'h001));
  wire tx_done = tx_active && tx_adv && tx_rd_last;

  // buffer ownership and the in-order transmit queue
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      buf_full <= 8'h00;
      q_wr <= 4'h0;
      for (int i = 0; i < `WBAF_UP_BUFS; i++) begin
        buf_len[i] <= 11'h000;
        tx_q[i] <= 3'h0;
      end
    end else begin
      if (forward) begin
        buf_full[wr_buf] <= 1'b1;
        buf_len[wr_buf] <= wr_cnt;
        tx_q[q_wr[2:0]] <= wr_buf;
        q_wr <= q_wr + 4'h1;
      end
      if (tx_done) begin
        buf_full[tx_buf] <= 1'b0;
      end
    end
  end

  // output register refills whenever empty or accepted
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_active <= 1'b0;
      tx_buf <= 3'h0;
      tx_rd <= 11'h000;
      q_rd <= 4'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else if (tx_adv) begin
      if (tx_active) begin
        tx_valid <= 1'b1;
        tx_data <= up_mem[{tx_buf, tx_rd}];
        tx_last <= tx_rd_last;
        tx_rd <= tx_rd + 11'h001;
        tx_active <= !tx_rd_last;
      end else begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        if (!q_empty) begin
          tx_active <= 1'b1;
          tx_buf <= tx_q[q_rd[2:0]];
          q_rd <= q_rd + 4'h1;
          tx_rd <= 11'h000;
        end
      end
    end
  end

  assign rf_tx_valid_o = tx_valid;
  assign rf_tx_data_o = tx_data;
  assign rf_tx_last_o = tx_last;

  // receive decode; addresses only looked at in check, after crc
  wire rx_start = rf_rx_valid_i && (rx_state == RX_IDLE);
  wire rx_check = (rx_state == RX_CHECK);
  wire rx_good = rx_crc_ok && !rx_long && (rx_cnt >= `WBAF_HDR_BYTES);
  wire rx_dst_local = |hit_rx_dst;
  wire delete_req = rx_check && rx_good;
  logic dl_pending;
  wire dl_start = rx_check && rx_good && (!dl_filter || rx_dst_local);
  wire rx_we = rf_rx_valid_i && ((rx_start && !dl_pending)
               || (rx_state == RX_STORE && rx_cnt < `WBAF_FRAME_MAX));
  wire [10:0] rx_waddr = rx_start ? 11'h000 : rx_cnt;

  // radio frame intake; a frame arriving while one waits to download is dropped
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 11'h000;
      rx_long <= 1'b0;
      rx_hdr <= 96'h0;
      rx_crc_ok <= 1'b0;
      ack <= 1'b0;
      rx_drop <= 1'b0;
    end else begin
      ack <= 1'b0;
      rx_drop <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (rf_rx_valid_i && dl_pending) begin
            rx_drop <= 1'b1;
            rx_state <= rf_rx_last_i ? RX_IDLE : RX_DROP;
          end else if (rf_rx_valid_i) begin
            rx_cnt <= 11'h001;
            rx_long <= 1'b0;
            rx_hdr <= {88'h0, rf_rx_data_i};
            rx_crc_ok <= rf_rx_crc_ok_i;
            rx_state <= rf_rx_last_i ? RX_CHECK : RX_STORE;
          end
        end
        RX_STORE: begin
          if (rf_rx_valid_i) begin
            if (rx_cnt < `WBAF_FRAME_MAX) begin
              rx_cnt <= rx_cnt + 11'h001;
            end else begin
              rx_long <= 1'b1;
            end
            if (rx_cnt < `WBAF_HDR_BYTES) begin
              rx_hdr <= {rx_hdr[87:0], rf_rx_data_i};
            end
            if (rf_rx_last_i) begin
              rx_crc_ok <= rf_rx_crc_ok_i;
              rx_state <= RX_CHECK;
            end
          end
        end
        RX_CHECK: begin
          ack <= rx_good && (!ack_en || rx_dst_local);
          rx_drop <= !rx_good;
          rx_state <= RX_IDLE;
        end
        RX_DROP: begin
          if (rf_rx_valid_i && rf_rx_last_i) begin
            rx_state <= RX_IDLE;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  assign ack_o = ack;
  assign rx_drop_o = rx_drop;

  // receive buffer storage
  always_ff @(posedge clock_i) begin
    if (rx_we) begin
      rx_mem[rx_waddr] <= rf_rx_data_i;
    end
  end

  // download reader into the fifo; the wired side can stall it
  wbaf_stream_if #(.WIDTH(`WBAF_DL_FIFO_W)) dl_in ();
  wbaf_stream_if #(.WIDTH(`WBAF_DL_FIFO_W)) dl_out ();
  logic [10:0] dl_len;
  logic [10:0] dl_rd;
  logic stage_valid;
  logic [8:0] stage_data;

  wire dl_adv = !stage_valid || dl_in.ready;
  wire dl_rd_last = (dl_rd == (dl_len - 11'h001));

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dl_pending <= 1'b0;
      dl_len <= 11'h000;
      dl_rd <= 11'h000;
      stage_valid <= 1'b0;
      stage_data <= 9'h000;
    end else if (dl_start) begin
      dl_pending <= 1'b1;
      dl_len <= rx_cnt;
      dl_rd <= 11'h000;
    end else if (dl_adv) begin
      stage_valid <= dl_pending;
      if (dl_pending) begin
        stage_data <= {dl_rd_last, rx_mem[dl_rd]};
        dl_rd <= dl_rd + 11'h001;
        dl_pending <= !dl_rd_last;
      end
    end
  end

  assign dl_in.valid = stage_valid;
  assign dl_in.data = stage_data;
  assign dl_out.ready = dl_ready_i;
  assign dl_valid_o = dl_out.valid;
  assign dl_data_o = dl_out.data[7:0];
  assign dl_last_o = dl_out.data[8];

  wbaf_fifo #(
    .WIDTH(`WBAF_DL_FIFO_W),
    .DEPTH(`WBAF_DL_FIFO_DEPTH)
  ) u_dl_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_s(dl_in),
    .out_s(dl_out)
  );

  // learned table: one slot picked for a new address
  wire learn_any_hit = |hit_learn;
  wire [4:0] free_slot = first_set(ent_free);

  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_ent
      assign hit_up_dst[g] = ent_valid[g] && (ent_mac[g] == up_hdr[95:48]);
      assign hit_learn[g] = ent_valid[g] && (ent_mac[g] == up_hdr[47:0]);
      assign hit_rx_dst[g] = ent_valid[g] && (ent_mac[g] == rx_hdr[95:48]);
      assign hit_rx_src[g] = ent_valid[g] && (ent_mac[g] == rx_hdr[47:0]);
      assign ent_free[g] = !ent_valid[g];
      assign tbl_valid_o[g] = ent_valid[g];

      // full table: no free slot means no insert
      wire ins_here = learn_req && (hit_learn[g]
                      || (!learn_any_hit && free_slot[4] && free_slot[3:0] == 4'(g)));
      wire del_here = delete_req && hit_rx_src[g];
      wire expire_here = ent_valid[g] && (ent_age[g] >= aging_s);

      // learning wins over removal in the same cycle
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          ent_valid[g] <= 1'b0;
          ent_mac[g] <= 48'h0;
          ent_age[g] <= 16'h0000;
        end else if (ins_here) begin
          ent_valid[g] <= 1'b1;
          ent_mac[g] <= up_hdr[47:0];
          ent_age[g] <= 16'h0000;
        end else if (del_here || expire_here) begin
          ent_valid[g] <= 1'b0;
        end else if (tick && ent_valid[g] && ent_age[g] != 16'hffff) begin
          ent_age[g] <= ent_age[g] + 16'h0001;
        end
      end
    end
  endgenerate

  assign up_buf_busy_o = buf_full;

endmodule

// ==== wbaf_defs.svh ====
`ifndef WBAF_DEFS_SVH
`define WBAF_DEFS_SVH

// clock and timing
`define WBAF_CLK_HZ 250000000
`define WBAF_TICK_S 1
`define WBAF_TICK_CYCLES (`WBAF_CLK_HZ * `WBAF_TICK_S)
`define WBAF_AGING_MIN 5
`define WBAF_AGING_S (16'(`WBAF_AGING_MIN * 60))

// upload buffers and frame geometry
`define WBAF_UP_BUFS 8
`define WBAF_BUF_AW 11
`define WBAF_BUF_DEPTH 2048
`define WBAF_FRAME_MAX 11'd1536
`define WBAF_HDR_BYTES 11'd12

// learned address table
`define WBAF_TBL_ENTRIES 16

// download fifo
`define WBAF_DL_FIFO_W 9
`define WBAF_DL_FIFO_DEPTH 16

// configuration reset values
`define WBAF_RST_ACK_EN 1'b1
`define WBAF_RST_TX_FILTER 1'b1
`define WBAF_RST_DL_FILTER 1'b1
`define WBAF_RST_LOOP_DETECT 1'b1
`define WBAF_RST_DUP_TRACK 1'b0
`define WBAF_RST_COLLIDE 1'b1

`endif

// ==== wbaf_pkg.sv ====
package wbaf_pkg;

  typedef logic [47:0] wbaf_mac_type;

  typedef enum logic [2:0] {
    WR_IDLE,
    WR_STORE,
    WR_COMMIT,
    WR_COLLIDE,
    WR_DISCARD
  } wbaf_wr_state_type;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_STORE,
    RX_CHECK,
    RX_DROP
  } wbaf_rx_state_type;

endpackage

// ==== wbaf_stream_if.sv ====
// byte stream carrier between the bridge core and its fifo
interface wbaf_stream_if #(parameter int WIDTH = 9);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ==== wbaf_fifo.sv ====
`include "wbaf_defs.svh"

module wbaf_fifo #(
  parameter int WIDTH = `WBAF_DL_FIFO_W,
  parameter int DEPTH = `WBAF_DL_FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_i,
  wbaf_stream_if.snk in_s,
  wbaf_stream_if.src out_s
);
  import wbaf_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty without a counter
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign push = in_s.valid && !full;
  assign pop = out_s.valid && out_s.ready;
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_ptr[AW-1:0]];

  // pointers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // storage, no reset needed: never read while empty
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_s.data;
    end
  end

endmodule

// ==== wbaf_top_props.sv ====
module wbaf_top_props (
  input logic clock_i,
  input logic reset_i,
  input logic up_valid_i,
  input logic up_last_i,
  input logic collision_o,
  input logic cfg_ack_en_o,
  input logic cfg_tx_filter_o,
  input logic cfg_dl_filter_o,
  input logic cfg_loop_detect_o,
  input logic cfg_dup_track_o,
  input logic cfg_collide_o,
  input logic rf_tx_valid_o,
  input logic [7:0] rf_tx_data_o,
  input logic rf_tx_last_o,
  input logic rf_tx_ready_i,
  input logic rf_rx_valid_i,
  input logic rf_rx_last_i,
  input logic rf_rx_crc_ok_i,
  input logic ack_o,
  input logic rx_drop_o,
  input logic dl_valid_o,
  input logic [7:0] dl_data_o,
  input logic dl_ready_i,
  input logic [7:0] up_buf_busy_o,
  input logic [15:0] tbl_valid_o
);
  // single clock domain
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // power-up state
  a_reset_defaults: assert property (
    $fell(reset_i) |-> cfg_ack_en_o && cfg_tx_filter_o && cfg_dl_filter_o &&
      cfg_loop_detect_o && !cfg_dup_track_o && cfg_collide_o)
    else $error("bad reset config");
  a_table_empty: assert property (
    $fell(reset_i) |-> tbl_valid_o == 16'h0000 && up_buf_busy_o == 8'h00)
    else $error("not empty after reset");
  // new entry only after a wired frame end
  a_learn_cause: assert property (
    (tbl_valid_o & ~$past(tbl_valid_o)) != 16'h0000 |-> $past(up_valid_i && up_last_i, 2))
    else $error("entry without frame");
  // collision needs all buffers taken and collide mode, held to the last byte
  a_collide_cause: assert property (
    $rose(collision_o) |-> up_buf_busy_o == 8'hff && up_valid_i)
    else $error("collision with free buffer");
  a_discard_quiet: assert property (
    $rose(collision_o) |-> cfg_collide_o)
    else $error("collision in discard mode");
  a_collide_hold: assert property (
    collision_o && !(up_valid_i && up_last_i) |=> collision_o)
    else $error("collision dropped early");
  // ack only for a good frame
  a_ack_cause: assert property (
    ack_o |-> $past(rf_rx_valid_i && rf_rx_last_i && rf_rx_crc_ok_i, 2))
    else $error("ack without good frame");
  a_badcrc_noack: assert property (
    rf_rx_valid_i && rf_rx_last_i && !rf_rx_crc_ok_i |-> ##2 !ack_o)
    else $error("ack for bad frame");
  a_drop_excl: assert property (
    rx_drop_o |-> !ack_o)
    else $error("dropped and acked");
  // stalled streams hold their byte
  a_tx_hold: assert property (
    rf_tx_valid_o && !rf_tx_ready_i |=> rf_tx_valid_o && $stable(rf_tx_data_o) &&
      $stable(rf_tx_last_o))
    else $error("radio byte moved");
  a_dl_hold: assert property (
    dl_valid_o && !dl_ready_i |=> dl_valid_o && $stable(dl_data_o))
    else $error("download byte moved");
endmodule

bind wbaf_top wbaf_top_props u_props (.*);

// ==== wbaf_station.sv ====
module wbaf_station import wbaf_pkg::*; (
  input wire logic clock_i,
  input wire logic collision_i,
  input wire logic stall_i,
  input wire logic dl_valid_i,
  input wire logic dl_last_i,
  output logic up_valid_o,
  output logic [7:0] up_data_o,
  output logic up_last_o,
  output logic dl_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int dl_frames = 0;
  logic dl_mid = 1'b0;
  initial begin
    up_valid_o = 1'b0;
    up_data_o = 8'h00;
    up_last_o = 1'b0;
  end
  // download side may stall at random; frames counted when taken
  assign dl_ready_o = !stall_i;
  always @(posedge clock_i) begin
    if (dl_valid_i && dl_ready_o && dl_last_i) dl_frames++;
  end
  // offer a 14-byte frame; back off longer after each collision
  task automatic send(input wbaf_mac_type dst, input wbaf_mac_type src, input int tries,
                      output logic col);
    logic [95:0] hdr;
    hdr = {dst, src};
    for (int t = 0; t < tries; t++) begin
      col = 1'b0;
      for (int i = 0; i < 14; i++) begin
        @(negedge clock_i);
        col = col | collision_i;
        up_valid_o = 1'b1;
        up_data_o = (i < 12) ? hdr[95 - 8*i -: 8] : 8'(i);
        up_last_o = (i == 13);
      end
      @(negedge clock_i);
      col = col | collision_i;
      up_valid_o = 1'b0;
      up_last_o = 1'b0;
      up_data_o = ~up_data_o; // released bus shows no stale byte
      repeat (2 + 20 * t) @(negedge clock_i);
      if (!col) break;
    end
  endtask
endmodule

// ==== tb.sv ====
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); end end
module tb import wbaf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, reset_i = 1'b1, cfg_write_i = 1'b0, tx_go = 1'b0, stall = 1'b0;
  logic cfg_ack_en_i = 1'b1, cfg_tx_filter_i = 1'b1, cfg_dl_filter_i = 1'b1;
  logic cfg_loop_detect_i = 1'b1, cfg_dup_track_i = 1'b0, cfg_collide_i = 1'b1;
  logic [15:0] cfg_aging_s_i = 16'h0000;
  logic rf_tx_ready_i = 1'b0, rf_rx_valid_i = 1'b0, rf_rx_last_i = 1'b0;
  logic rf_rx_crc_ok_i = 1'b0, tx_mid = 1'b0;
  logic [7:0] rf_rx_data_i = 8'h00, lfsr = 8'h57, d;
  wire logic cfg_ack_en_o, cfg_tx_filter_o, cfg_dl_filter_o, cfg_loop_detect_o;
  wire logic cfg_dup_track_o, cfg_collide_o, up_valid_i, up_last_i, collision_o, dl_ready_i;
  wire logic rf_tx_valid_o, rf_tx_last_o, ack_o, rx_drop_o, dl_valid_o, dl_last_o;
  wire logic [7:0] up_data_i, rf_tx_data_o, dl_data_o, up_buf_busy_o;
  wire logic [15:0] cfg_aging_s_o, tbl_valid_o;
  wire logic [21:0] cfg_seen = {cfg_ack_en_o, cfg_tx_filter_o, cfg_dl_filter_o,
    cfg_loop_detect_o, cfg_dup_track_o, cfg_collide_o, cfg_aging_s_o};
  int fails = 0, check_count = 0, tx_frames = 0, ack_n = 0, drop_n = 0;
  logic [7:0] tx_q[$];

  wbaf_top #(.TICK_CYCLES(20)) u_dut (.*);
  wbaf_station u_sta (.clock_i(clock_i), .collision_i(collision_o), .stall_i(stall),
    .dl_valid_i(dl_valid_o), .dl_last_i(dl_last_o), .up_valid_o(up_valid_i),
    .up_data_o(up_data_i), .up_last_o(up_last_i), .dl_ready_o(dl_ready_i));

  always #2 clock_i = ~clock_i;
  // random backpressure and stalls, off the sampling edge
  always @(negedge clock_i) begin
    lfsr <= lfsr_next(lfsr);
    rf_tx_ready_i <= tx_go & lfsr[0];
    stall <= lfsr[3] & lfsr[5];
  end
  // radio and pulse monitors; registered outputs, so the edge value is settled
  always @(posedge clock_i) begin
    if (rf_tx_valid_o && rf_tx_ready_i) begin
      if (!tx_mid) tx_q.push_back(rf_tx_data_o);
      tx_mid = !rf_tx_last_o;
      if (rf_tx_last_o) tx_frames++;
    end
    if (ack_o) ack_n++;
    if (rx_drop_o) drop_n++;
  end

  function automatic wbaf_mac_type mac(input logic [7:0] k);
    return {k, 40'h00_0000_0001};
  endfunction
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // with acks or download filter off every good frame passes
  function automatic int exp_pass(input logic crc, input logic en, input logic hit);
    return int'(crc && (!en || hit));
  endfunction

  task automatic cfg(input logic [5:0] b, input logic [15:0] age);
    @(negedge clock_i);
    {cfg_ack_en_i, cfg_tx_filter_i, cfg_dl_filter_i, cfg_loop_detect_i, cfg_dup_track_i,
     cfg_collide_i} = b;
    cfg_aging_s_i = age;
    cfg_write_i = 1'b1;
    @(negedge clock_i);
    cfg_write_i = 1'b0;
    `CHK("config", {b, age}, cfg_seen)
  endtask
  task automatic wait_tx(input int n);
    for (int i = 0; i < 3000 && tx_frames < n; i++) @(negedge clock_i);
    repeat (60) @(negedge clock_i);
    `CHK("radio frames", n, tx_frames)
  endtask
  // one radio frame; crc flag is random except on the last byte
  task automatic rx(input wbaf_mac_type dst, input wbaf_mac_type src, input logic crc,
                    input logic hit);
    logic [95:0] hdr = {dst, src};
    int a0 = ack_n, d0 = u_sta.dl_frames, r0 = drop_n;
    for (int i = 0; i < 14; i++) begin
      @(negedge clock_i);
      rf_rx_valid_i = 1'b1;
      rf_rx_data_i = (i < 12) ? hdr[95 - 8*i -: 8] : lfsr;
      rf_rx_last_i = (i == 13);
      rf_rx_crc_ok_i = (i == 13) ? crc : lfsr[2];
    end
    @(negedge clock_i);
    rf_rx_valid_i = 1'b0;
    rf_rx_last_i = 1'b0;
    rf_rx_data_i = ~rf_rx_data_i;
    repeat (80) @(negedge clock_i);
    `CHK("acks", a0 + exp_pass(crc, cfg_ack_en_i, hit), ack_n)
    `CHK("downloads", d0 + exp_pass(crc, cfg_dl_filter_i, hit), u_sta.dl_frames)
    `CHK("drops", r0 + int'(!crc), drop_n)
  endtask
  task automatic results;
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    results();
  end
  initial begin
    logic col;
    repeat (20) @(negedge clock_i);
    reset_i = 1'b0;
    `CHK("defaults", {6'h3d, 16'h012c}, cfg_seen)
    `CHK("empty", 24'h000000, {tbl_valid_o, up_buf_busy_o})
    cfg(6'b111101, 16'hffff);
    tx_go = 1'b1;
    d = lfsr | 8'h80;
    u_sta.send(mac(d), mac(8'h01), 1, col);
    `CHK("learned", 1'b1, tbl_valid_o[0])
    wait_tx(1);
    `CHK("radio dst", d, tx_q[0])
    // local destination stays local unless the filter is off
    u_sta.send(mac(8'h01), mac(8'h02), 1, col);
    wait_tx(1);
    cfg(6'b101101, 16'hffff);
    u_sta.send(mac(8'h01), mac(8'h02), 1, col);
    wait_tx(2);
    cfg(6'b111101, 16'hffff);
    // radio stalled: fill all upload buffers, then collide and discard
    tx_go = 1'b0;
    for (int i = 0; i < 8; i++) u_sta.send(mac(8'h10 + 8'(i)), mac(8'h20 + 8'(i)), 1, col);
    `CHK("buffers busy", 8'hff, up_buf_busy_o)
    u_sta.send(mac(8'h18), mac(8'h28), 1, col);
    `CHK("collision", 1'b1, col)
    cfg(6'b111100, 16'hffff);
    u_sta.send(mac(8'h19), mac(8'h29), 1, col);
    `CHK("no collision", 1'b0, col)
    cfg(6'b111101, 16'hffff);
    tx_go = 1'b1;
    u_sta.send(mac(8'h18), mac(8'h28), 8, col);
    `CHK("re-offer", 1'b0, col)
    wait_tx(11);
    for (int i = 0; i < 9; i++) `CHK("radio order", 8'h10 + 8'(i), tx_q[2 + i])
    // fill the table; one more source must not get in
    for (int i = 0; i < 16 && tbl_valid_o !== 16'hffff; i++)
      u_sta.send(mac(8'hc0), mac(8'h40 + 8'(i)), 1, col);
    `CHK("table full", 16'hffff, tbl_valid_o)
    u_sta.send(mac(8'hc0), mac(8'h7f), 1, col);
    rx(mac(8'h7f), mac(8'hee), 1'b1, 1'b0);
    rx(mac(8'h40), mac(8'hee), 1'b1, 1'b1);
    rx(mac(8'h40), mac(8'hee), 1'b0, 1'b1);
    rx(mac(8'hc0), mac(8'h40), 1'b1, 1'b0);
    `CHK("entries", 15, $countones(tbl_valid_o))
    rx(mac(8'h40), mac(8'hee), 1'b1, 1'b0);
    cfg(6'b010101, 16'hffff);
    rx(mac(8'hc0), mac(8'hee), 1'b1, 1'b0);
    // aging of 3 ticks of 20 cycles; a second frame restarts it
    cfg(6'b111101, 16'd3);
    repeat (100) @(negedge clock_i);
    `CHK("aged out", 16'h0000, tbl_valid_o)
    u_sta.send(mac(8'hc0), mac(8'h50), 1, col);
    repeat (25) @(negedge clock_i);
    u_sta.send(mac(8'hc0), mac(8'h50), 1, col);
    repeat (25) @(negedge clock_i);
    `CHK("refreshed", 1'b1, |tbl_valid_o)
    repeat (60) @(negedge clock_i);
    `CHK("expired", 16'h0000, tbl_valid_o)
    results();
  end
endmodule
